// ===== ddc_cfg.svh
// Constants of the dual converter control block: register offsets,
// control field positions, reset values and data formats.
// Included by the package and by every design file; guarded.
`ifndef DDC_CFG_SVH
`define DDC_CFG_SVH

`define DDC_DW          12
`define DDC_ADR_W       8
`define DDC_SEL_WORD    4'hf
`define DDC_HW_TRIG_N   7
// Register byte offsets
`define DDC_OFF_CTL     8'h00
`define DDC_OFF_SWT     8'h04
`define DDC_OFF_R12_0   8'h08
`define DDC_OFF_L12_0   8'h0c
`define DDC_OFF_R8_0    8'h10
`define DDC_OFF_R12_1   8'h14
`define DDC_OFF_L12_1   8'h18
`define DDC_OFF_R8_1    8'h1c
`define DDC_OFF_DR12    8'h20
`define DDC_OFF_DL12    8'h24
`define DDC_OFF_DR8     8'h28
`define DDC_OFF_OUT_0   8'h2c
`define DDC_OFF_OUT_1   8'h30
`define DDC_OFF_MODE    8'h34
// Control register layout, per channel half of 16 bits
`define DDC_CTL_RST     32'h00000000
`define DDC_CTL_MASK    32'h1fff1fff
`define DDC_CH_BITS     16
`define DDC_EN_BIT      0
`define DDC_BOFF_BIT    1
`define DDC_TEN_BIT     2
`define DDC_TSEL_LSB    3
`define DDC_TSEL_MSB    5
`define DDC_WM_LSB      6
`define DDC_WM_MSB      7
`define DDC_WB_LSB      8
`define DDC_WB_MSB      11
`define DDC_DMA_BIT     12
`define DDC_TSEL_SOFT   3'h7
`define DDC_MODE_CONC   0
// Noise generator
`define DDC_WB_FULL     4'hb
`define DDC_LFSR_SEED   12'haaa
`define DDC_MASK_FULL   12'hfff
// Holding data formats
`define DDC_FMT_R12     2'h0
`define DDC_FMT_L12     2'h1
`define DDC_FMT_R8      2'h2
`define DDC_R8_PAD      4'h0

`endif

// ===== ddc_pkg.sv
// Types shared by the dual converter control block.
// Assumes ddc_cfg.svh is on the include path.
`default_nettype none
`include "ddc_cfg.svh"

package ddc_pkg;

    // Noise kind field codes
    typedef enum logic [1:0] {
        DDC_NOISE_OFF  = 2'b00,
        DDC_NOISE_LFSR = 2'b01,
        DDC_NOISE_TRI  = 2'b10,
        DDC_NOISE_TRIX = 2'b11
    } ddc_noise_kind_t;

    // Whole state of one noise generator
    typedef struct packed {
        logic [`DDC_DW-1:0] lfsr;
        logic [`DDC_DW-1:0] tri_cnt;
        logic               down;
    } ddc_noise_state_t;

    // Whole state of the control block
    typedef struct packed {
        logic [31:0]                  ctl;
        logic [1:0]                   swt;
        logic                         conc;
        logic [1:0][`DDC_DW-1:0]      hold;
        logic [1:0][`DDC_DW-1:0]      outv;
        logic [`DDC_HW_TRIG_N-1:0]    trig_prev;
        logic [1:0]                   dma;
        logic [1:0]                   pwr;
        logic [1:0]                   buf_on;
        logic                         ack;
        logic [31:0]                  rdata;
    } ddc_state_t;

    // Mask of the low bits for a noise width code; codes 11 and up give 12 bits
    function automatic logic [`DDC_DW-1:0] ddc_width_mask(input logic [3:0] f);
        if (f >= `DDC_WB_FULL) begin
            return `DDC_MASK_FULL;
        end
        return `DDC_MASK_FULL >> (`DDC_WB_FULL - f);
    endfunction

endpackage
`default_nettype wire

// ===== ddc_noise.sv
// Noise generator for one converter channel: LFSR and triangle.
// Steps once per transfer pulse from the control block; output is combinational.
`timescale 1ns/10ps
`default_nettype none
`include "ddc_cfg.svh"

module ddc_noise
    import ddc_pkg::*;
(
    input  wire logic                 clk,        // Peripheral clock
    input  wire logic                 rst,        // Synchronous reset
    input  wire logic                 step,       // Advance one noise step
    input  wire ddc_noise_kind_t      kind,       // Selected noise kind
    input  wire logic [3:0]           width_sel,  // Noise width code
    output logic      [`DDC_DW-1:0]   noise       // Noise term to add
);

    ddc_noise_state_t s, n;
    logic [`DDC_DW-1:0] mask;
    logic               fb;

    assign mask = ddc_width_mask(width_sel);
    assign fb   = s.lfsr[11] ^ s.lfsr[5] ^ s.lfsr[3] ^ s.lfsr[0];

    // Next state of both generators
    always_comb begin
        n = s;
        if (step) begin
            n.lfsr = {s.lfsr[10:0], fb};
            if (s.tri_cnt > mask) begin
                n.tri_cnt = mask;
                n.down    = 1'b1;
            end else if (!s.down) begin
                if (s.tri_cnt == mask) begin
                    n.down    = 1'b1;
                    n.tri_cnt = s.tri_cnt - 12'h001;
                end else begin
                    n.tri_cnt = s.tri_cnt + 12'h001;
                end
            end else begin
                if (s.tri_cnt == 12'h000) begin
                    n.down    = 1'b0;
                    n.tri_cnt = s.tri_cnt + 12'h001;
                end else begin
                    n.tri_cnt = s.tri_cnt - 12'h001;
                end
            end
        end
    end

    // State register; LFSR seed is nonzero so it never locks up
    always_ff @(posedge clk) begin
        if (rst) begin
            s.lfsr    <= `DDC_LFSR_SEED;
            s.tri_cnt <= 12'h000;
            s.down    <= 1'b0;
        end else begin
            s <= n;
        end
    end

    always_comb begin
        unique case (kind)
            DDC_NOISE_OFF:  noise = 12'h000;
            DDC_NOISE_LFSR: noise = s.lfsr & mask;
            DDC_NOISE_TRI:  noise = s.tri_cnt & mask;
            DDC_NOISE_TRIX: noise = s.tri_cnt & mask;
        endcase
    end

    property p_lfsr_mask;
        @(posedge clk) disable iff (rst)
        kind == DDC_NOISE_LFSR |-> (noise & ~mask) == 12'h000 && noise == (s.lfsr & mask);
    endproperty
    a_lfsr_mask: assert property (p_lfsr_mask)
        else $error("LFSR noise not masked to width");

    property p_width_full;
        @(posedge clk) disable iff (rst)
        width_sel >= 4'hb |-> mask == 12'hfff;
    endproperty
    a_width_full: assert property (p_width_full)
        else $error("Wide noise code does not give twelve bits");

    property p_tri_turn;
        @(posedge clk) disable iff (rst)
        step && !s.down && s.tri_cnt == mask && $stable(width_sel)
            |=> s.down && s.tri_cnt == $past(mask) - 12'h001;
    endproperty
    a_tri_turn: assert property (p_tri_turn)
        else $error("Triangle did not turn at its maximum");

    property p_lfsr_step;
        @(posedge clk) disable iff (rst)
        !step |=> $stable(s.lfsr) && $stable(s.tri_cnt);
    endproperty
    a_lfsr_step: assert property (p_lfsr_step)
        else $error("Noise moved without a trigger");

    property p_off;
        @(posedge clk) disable iff (rst)
        kind == DDC_NOISE_OFF |-> noise == 12'h000;
    endproperty
    a_off: assert property (p_off)
        else $error("Noise present while disabled");

    c_tri_top: cover property (@(posedge clk) disable iff (rst)
        step && s.tri_cnt == mask && kind == DDC_NOISE_TRI);

endmodule // ddc_noise
`default_nettype wire

// ===== ddc_top.sv
// Dual 12-bit converter control logic with a classic Wishbone slave.
// Assumes timer and external-line triggers synchronous to clk, one clock.
//
// Overview of operation
// - Holding value from 12-bit right, 12-bit left, or 8-bit write padded zero.
// - Channel power follows enable bit 0 or bit 16.
// - Output buffer on unless buffer-off bit 1 or 17 is set.
// - Trigger enabled: transfer on event only; else transfer automatically.
// - Three-bit select picks one of six timers, external line or software.
// - Software sets a trigger bit; it is the event under select seven.
// - Hardware trigger with DMA enabled raises a request; software trigger never.
// - Noise kind field: off, LFSR, or triangle, used when triggered.
// - Noise width is field plus one, saturating at twelve bits.
// - LFSR noise uses only the low configured-width bits.
// - Triangle noise runs from zero to two to the width minus one.
// - Concurrent mode transfers both channels together; dual writes load both.
// - Each channel keeps its own noise settings in concurrent mode.
// - Control register resets to zero: all channels off.
// - Hardware clears a software trigger bit once it is taken.
// - Output data registers are read only and show converter input.
`timescale 1ns/10ps
`default_nettype none
`include "ddc_cfg.svh"

module ddc_top
    import ddc_pkg::*;
(
    input  wire logic                  clk,                  // 40 MHz clock
    input  wire logic                  rst,                  // Sync reset, high
    input  wire logic                  wb_cyc_i,             // Bus cycle
    input  wire logic                  wb_stb_i,             // Bus strobe
    input  wire logic                  wb_we_i,              // Write enable
    input  wire logic [3:0]            wb_sel_i,             // Byte selects
    input  wire logic [`DDC_ADR_W-1:0] wb_adr_i,             // Byte address
    input  wire logic [31:0]           wb_dat_i,             // Write data
    output logic      [31:0]           wb_dat_o,             // Read data
    output logic                       wb_ack_o,             // Acknowledge
    input  wire logic                  timer_five_trig_out,  // Trigger code 0
    input  wire logic                  timer_two_trig_out,   // Trigger code 1
    input  wire logic                  timer_six_trig_out,   // Trigger code 2
    input  wire logic                  timer_four_trig_out,  // Trigger code 3
    input  wire logic                  timer_one_trig_out,   // Trigger code 4
    input  wire logic                  timer_three_trig_out, // Trigger code 5
    input  wire logic                  ext_line_nine,        // Trigger code 6
    output logic      [1:0]            channel_power_on,     // Converter powered
    output logic      [1:0]            out_buffer_on,        // Output buffer on
    output logic      [1:0]            dma_request,          // DMA request pulse
    output logic      [`DDC_DW-1:0]    output_value0,        // Channel 0 code
    output logic      [`DDC_DW-1:0]    output_value1         // Channel 1 code
);

    ddc_state_t s, n;

    logic [`DDC_HW_TRIG_N-1:0] hw_in;
    logic [`DDC_HW_TRIG_N:0]   hw_rise;
    logic [`DDC_ADR_W-1:0]     word_adr;
    logic                      bus_req;
    logic                      bus_wr;
    logic [1:0]                ena;
    logic [1:0]                ten;
    logic [1:0]                dmaen;
    logic [1:0]                is_sw;
    logic [1:0]                raw_ev;
    logic [1:0]                xfer;
    logic [1:0]                sw_take;
    logic [1:0]                hw_ev;
    logic [1:0][`DDC_DW-1:0]   noise_w;
    logic [1:0][`DDC_DW-1:0]   sum_w;

    localparam logic [1:0][`DDC_ADR_W-1:0] OFF_R12 = {`DDC_OFF_R12_1, `DDC_OFF_R12_0};
    localparam logic [1:0][`DDC_ADR_W-1:0] OFF_L12 = {`DDC_OFF_L12_1, `DDC_OFF_L12_0};
    localparam logic [1:0][`DDC_ADR_W-1:0] OFF_R8  = {`DDC_OFF_R8_1, `DDC_OFF_R8_0};

    function automatic logic pick_trigger(input logic [2:0]              sel,
                                          input logic [`DDC_HW_TRIG_N:0] rise,
                                          input logic                    sw);
        if (sel == `DDC_TSEL_SOFT) begin
            return sw;
        end
        return rise[sel];
    endfunction

    function automatic logic [`DDC_DW-1:0] load_hold(input logic [1:0]  fmt,
                                                     input logic [15:0] d);
        case (fmt)
            `DDC_FMT_L12: return d[15:4];
            `DDC_FMT_R8:  return {d[7:0], `DDC_R8_PAD};
            default:      return d[11:0];
        endcase
    endfunction

    // Trigger inputs in select-code order, with edge detection
    assign hw_in   = {ext_line_nine, timer_three_trig_out, timer_one_trig_out,
                      timer_four_trig_out, timer_six_trig_out, timer_two_trig_out,
                      timer_five_trig_out};
    assign hw_rise = {1'b0, hw_in & ~s.trig_prev};

    // Bus decode: one request per ack, word addresses only
    assign word_adr = {wb_adr_i[`DDC_ADR_W-1:2], 2'b00};
    assign bus_req  = wb_cyc_i & wb_stb_i & ~s.ack;
    // Writes land at the edge where the master sees ack high, while it
    // still holds address and data; the request edge only prepares the
    // answer, so a master that stalls never sees an early write.
    // Word writes only
    assign bus_wr   = wb_cyc_i & wb_stb_i & s.ack & wb_we_i & (wb_sel_i == `DDC_SEL_WORD);

    // Per-channel control decode, trigger event and noise generator
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            logic [`DDC_CH_BITS-1:0] f;
            logic [2:0]              tsel;
            assign f        = s.ctl[g*`DDC_CH_BITS +: `DDC_CH_BITS];
            assign tsel     = f[`DDC_TSEL_MSB:`DDC_TSEL_LSB];
            assign ena[g]   = f[`DDC_EN_BIT];
            assign ten[g]   = f[`DDC_TEN_BIT];
            assign dmaen[g] = f[`DDC_DMA_BIT];
            assign is_sw[g] = (tsel == `DDC_TSEL_SOFT);
            assign raw_ev[g]  = ena[g] & ten[g] & pick_trigger(tsel, hw_rise, s.swt[g]);
            assign sw_take[g] = raw_ev[g] & is_sw[g];
            assign hw_ev[g]   = raw_ev[g] & ~is_sw[g];
            assign sum_w[g]   = s.hold[g] + noise_w[g];

            ddc_noise u_noise (
                .clk       (clk),
                .rst       (rst),
                .step      (xfer[g]),
                .kind      (ddc_noise_kind_t'(f[`DDC_WM_MSB:`DDC_WM_LSB])),
                .width_sel (f[`DDC_WB_MSB:`DDC_WB_LSB]),
                .noise     (noise_w[g])
            );
        end
    endgenerate

    assign xfer = s.conc ? ({2{|raw_ev}} & ena & ten) : raw_ev;

    // Next state of the whole block
    always_comb begin
        n           = s;
        n.ack       = bus_req;
        n.trig_prev = hw_in;
        n.dma       = hw_ev & dmaen;
        n.pwr       = ena;
        n.buf_on    = ~{s.ctl[`DDC_CH_BITS + `DDC_BOFF_BIT], s.ctl[`DDC_BOFF_BIT]};

        // Control and mode writes
        if (bus_wr && word_adr == `DDC_OFF_CTL) begin
            n.ctl = wb_dat_i & `DDC_CTL_MASK;
        end
        if (bus_wr && word_adr == `DDC_OFF_MODE) begin
            n.conc = wb_dat_i[`DDC_MODE_CONC];
        end
        n.swt = s.swt & ~sw_take;
        if (bus_wr && word_adr == `DDC_OFF_SWT) begin
            n.swt = n.swt | wb_dat_i[1:0];
        end

        for (int c = 0; c < 2; c++) begin
            if (bus_wr && word_adr == OFF_R12[c]) begin
                n.hold[c] = load_hold(`DDC_FMT_R12, wb_dat_i[15:0]);
            end
            if (bus_wr && word_adr == OFF_L12[c]) begin
                n.hold[c] = load_hold(`DDC_FMT_L12, wb_dat_i[15:0]);
            end
            if (bus_wr && word_adr == OFF_R8[c]) begin
                n.hold[c] = load_hold(`DDC_FMT_R8, wb_dat_i[15:0]);
            end
            if (xfer[c]) begin
                n.outv[c] = sum_w[c];
            end else if (ena[c] && !ten[c]) begin
                n.outv[c] = s.hold[c];
            end
        end

        if (bus_wr && word_adr == `DDC_OFF_DR12) begin
            n.hold[0] = load_hold(`DDC_FMT_R12, wb_dat_i[15:0]);
            n.hold[1] = load_hold(`DDC_FMT_R12, wb_dat_i[31:16]);
        end
        if (bus_wr && word_adr == `DDC_OFF_DL12) begin
            n.hold[0] = load_hold(`DDC_FMT_L12, wb_dat_i[15:0]);
            n.hold[1] = load_hold(`DDC_FMT_L12, wb_dat_i[31:16]);
        end
        if (bus_wr && word_adr == `DDC_OFF_DR8) begin
            n.hold[0] = load_hold(`DDC_FMT_R8, {8'h00, wb_dat_i[7:0]});
            n.hold[1] = load_hold(`DDC_FMT_R8, {8'h00, wb_dat_i[15:8]});
        end

        // Read data, zero for unmapped addresses
        n.rdata = 32'h00000000;
        if (bus_req && !wb_we_i) begin
            case (word_adr)
                `DDC_OFF_CTL:   n.rdata = s.ctl;
                `DDC_OFF_SWT:   n.rdata = {30'h0, s.swt};
                `DDC_OFF_R12_0: n.rdata = {20'h0, s.hold[0]};
                `DDC_OFF_L12_0: n.rdata = {16'h0, s.hold[0], 4'h0};
                `DDC_OFF_R8_0:  n.rdata = {24'h0, s.hold[0][11:4]};
                `DDC_OFF_R12_1: n.rdata = {20'h0, s.hold[1]};
                `DDC_OFF_L12_1: n.rdata = {16'h0, s.hold[1], 4'h0};
                `DDC_OFF_R8_1:  n.rdata = {24'h0, s.hold[1][11:4]};
                `DDC_OFF_DR12:  n.rdata = {4'h0, s.hold[1], 4'h0, s.hold[0]};
                `DDC_OFF_DL12:  n.rdata = {s.hold[1], 4'h0, s.hold[0], 4'h0};
                `DDC_OFF_DR8:   n.rdata = {16'h0, s.hold[1][11:4], s.hold[0][11:4]};
                `DDC_OFF_OUT_0: n.rdata = {20'h0, s.outv[0]};
                `DDC_OFF_OUT_1: n.rdata = {20'h0, s.outv[1]};
                `DDC_OFF_MODE:  n.rdata = {31'h0, s.conc};
                default:        n.rdata = 32'h00000000;
            endcase
        end
    end

    // State register; every field clears under reset, buffer flags too,
    // so buffers read on only from the first edge after release
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from the state register
    assign wb_dat_o         = s.rdata;
    assign wb_ack_o         = s.ack;
    assign channel_power_on = s.pwr;
    assign out_buffer_on    = s.buf_on;
    assign dma_request      = s.dma;
    assign output_value0    = s.outv[0];
    assign output_value1    = s.outv[1];

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_r8_load;
        bus_wr && word_adr == `DDC_OFF_R8_0 |=> s.hold[0] == {$past(wb_dat_i[7:0]), 4'h0};
    endproperty
    a_r8_load: assert property (p_r8_load)
        else $error("Eight-bit load not padded into holding value");

    property p_power;
        bus_wr && word_adr == `DDC_OFF_CTL |-> ##2 channel_power_on[1] == $past(wb_dat_i[16], 2);
    endproperty
    a_power: assert property (p_power)
        else $error("Channel 1 power does not follow its enable");

    property p_buffer;
        bus_wr && word_adr == `DDC_OFF_CTL |-> ##2 out_buffer_on[0] == !$past(wb_dat_i[1], 2);
    endproperty
    a_buffer: assert property (p_buffer)
        else $error("Channel 0 buffer does not follow its off bit");

    property p_auto;
        ena[0] && !ten[0] |=> output_value0 == $past(s.hold[0]);
    endproperty
    a_auto: assert property (p_auto)
        else $error("Automatic transfer missed");

    property p_wait_trig;
        ten[1] && !xfer[1] |=> $stable(output_value1);
    endproperty
    a_wait_trig: assert property (p_wait_trig)
        else $error("Output changed without a trigger");

    property p_dma_sw;
        sw_take[0] |=> !dma_request[0];
    endproperty
    a_dma_sw: assert property (p_dma_sw)
        else $error("DMA request on software trigger");

    property p_dma_hw;
        hw_ev[1] && dmaen[1] |=> dma_request[1] ##1 (dma_request[1] == $past(hw_ev[1] & dmaen[1]));
    endproperty
    a_dma_hw: assert property (p_dma_hw)
        else $error("Hardware trigger raised no single DMA pulse");

    property p_swt_clear;
        sw_take[0] && !(bus_wr && word_adr == `DDC_OFF_SWT) |=> !s.swt[0];
    endproperty
    a_swt_clear: assert property (p_swt_clear)
        else $error("Software trigger bit not cleared");

    property p_dual;
        bus_wr && word_adr == `DDC_OFF_DR12 |=>
            s.hold[0] == $past(wb_dat_i[11:0]) && s.hold[1] == $past(wb_dat_i[27:16]);
    endproperty
    a_dual: assert property (p_dual)
        else $error("Dual write did not load both holding values");

    property p_conc;
        s.conc && xfer[0] && ena[1] && ten[1] |-> xfer[1];
    endproperty
    a_conc: assert property (p_conc)
        else $error("Concurrent transfer not simultaneous");

    property p_sum;
        xfer[0] |=> output_value0 == $past(sum_w[0]);
    endproperty
    a_sum: assert property (p_sum)
        else $error("Output is not holding plus noise");

    property p_part_write;
        wb_cyc_i && wb_stb_i && s.ack && wb_we_i && wb_sel_i != 4'hf |=> $stable(s.ctl);
    endproperty
    a_part_write: assert property (p_part_write)
        else $error("Partial write changed the control register");

    property p_reset;
        disable iff (1'b0) rst |=> s.ctl == 32'h00000000 && dma_request == 2'b00;
    endproperty
    a_reset: assert property (p_reset)
        else $error("Control not zero after reset");

    c_sw_take: cover property (sw_take[0] ##1 output_value0 != $past(output_value0));
    c_dma:     cover property (dma_request[0]);
    c_conc:    cover property (s.conc && xfer == 2'b11);

endmodule // ddc_top
`default_nettype wire

// ===== ddc_trig_model.sv
// Timer and external-line trigger sources for the converter bench.
// Assumes one-cycle fire requests from the bench, on clk.
`timescale 1ns/10ps
`default_nettype none
module ddc_trig_model (
    input  wire logic       clk,  // Bench clock
    input  wire logic       rst,  // Sync reset
    input  wire logic [6:0] fire, // Pulse request per source
    output logic      [6:0] trig  // Trigger lines, idle low
);
    // One high cycle per request, low otherwise
    always_ff @(posedge clk) begin
        if (rst) begin
            trig <= 7'h00;
        end else begin
            trig <= fire;
        end
    end
endmodule // ddc_trig_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench of the dual converter control block.
// Assumes ddc_cfg.svh on the include path and ddc_trig_model beside it.
`timescale 1ns/10ps
`default_nettype none
`include "ddc_cfg.svh"
module tb_top;
    logic        clk, rst, cyc, stb, we, ack;
    logic [7:0]  adr;
    logic [31:0] dw, dr, rd, sd, c, d;
    logic [6:0]  fire, trig;
    logic [3:0]  sel, ws;
    logic [1:0]  pwr, bon, dma;
    logic [11:0] ov0, ov1, h, g;
    int          n_mismatch, samples_checked, cyc_n, n_dma, n_dma1, k;
    ddc_top u_ddc_top (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
        .timer_five_trig_out(trig[0]), .timer_two_trig_out(trig[1]),
        .timer_six_trig_out(trig[2]), .timer_four_trig_out(trig[3]),
        .timer_one_trig_out(trig[4]), .timer_three_trig_out(trig[5]),
        .ext_line_nine(trig[6]), .channel_power_on(pwr), .out_buffer_on(bon),
        .dma_request(dma), .output_value0(ov0), .output_value1(ov1));
    ddc_trig_model u_ddc_trig_model (.clk(clk), .rst(rst), .fire(fire), .trig(trig));
    // Clock of 25 ns
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Hang ceiling and count of DMA pulses
    always @(posedge clk) begin
        cyc_n++;
        n_dma += int'(dma[0] === 1'b1);
        n_dma1 += int'(dma[1] === 1'b1);
        if (cyc_n == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    function automatic logic [31:0] rnd();
        sd = sd ^ (sd << 13);
        sd = sd ^ (sd >> 17);
        sd = sd ^ (sd << 5);
        return sd;
    endfunction
    // Expected holding value: format 0 right 12, 1 left 12, 2 right 8
    function automatic logic [11:0] fmt_hold(input int f, input logic [31:0] v);
        return (f == 0) ? v[11:0] : (f == 1) ? v[15:4] : {v[7:0], 4'h0};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic single cycle, then a few cycles for outputs to settle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        sel <= ws;
        adr <= a;
        dw  <= v;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic pulse(input int s);
        @(posedge clk);
        fire[s] <= 1'b1;
        @(posedge clk);
        fire[s] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        sd = 32'haa064631;
        ws = 4'hf;
        {cyc, stb, we, sel, adr, dw, fire} = '0;
        rst = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        wb(0, `DDC_OFF_CTL, 0);
        chk(rd, `DDC_CTL_RST);
        chk(bon, 2'b11);
        for (int i = 0; i < 4; i++) begin
            c = rnd() & 32'h00030003;
            wb(1, `DDC_OFF_CTL, c);
            chk(pwr, {c[16], c[0]});
            chk(bon, {c[17], c[1]} ^ 2'b11);
        end
        // Byte-lane write must leave the control register alone
        ws = 4'h3;
        wb(1, `DDC_OFF_CTL, ~c);
        ws = 4'hf;
        wb(0, `DDC_OFF_CTL, 0);
        chk(rd, c);
        $display("test control done");
        wb(1, `DDC_OFF_CTL, 32'h00010001);
        for (int ch = 0; ch < 2; ch++) begin
            for (int f = 0; f < 3; f++) begin
                d = rnd();
                wb(1, 8'(8 + 12 * ch + 4 * f), d);
                chk(ch ? ov1 : ov0, fmt_hold(f, d));
            end
        end
        d = rnd();
        wb(1, `DDC_OFF_DR12, d);
        chk({ov1, ov0}, {d[27:16], d[11:0]});
        wb(1, `DDC_OFF_OUT_0, ~d);
        wb(0, `DDC_OFF_OUT_0, 0);
        chk(rd, {20'h0, d[11:0]});
        $display("test formats done");
        g = d[11:0];
        for (int s = 0; s < 7; s++) begin
            wb(1, `DDC_OFF_CTL, 32'h1005 | (s << 3));
            h = 12'(rnd());
            wb(1, `DDC_OFF_R12_0, {20'h0, h});
            k = n_dma;
            pulse((s + 1) % 7);
            chk(ov0, g);
            pulse(s);
            g = h;
            chk(ov0, g);
            chk(n_dma, k + 1);
        end
        $display("test hardware triggers done");
        for (int m = 0; m < 3; m++) begin
            wb(1, `DDC_OFF_CTL, 32'h103d | (m << 6));
            h = 12'(rnd());
            wb(1, `DDC_OFF_R12_0, {20'h0, h});
            k = n_dma;
            for (int j = 0; j < 3; j++) begin
                wb(1, `DDC_OFF_SWT, 1);
                chk(12'(ov0 - h) >> (m == 0 ? 0 : 1), 0);
                wb(0, `DDC_OFF_SWT, 0);
                chk(rd, 0);
            end
            chk(n_dma, k);
        end
        $display("test software trigger done");
        // Concurrent: both on timer code 2, DMA on channel 1 only,
        // channel 1 twelve-bit LFSR noise, channel 0 without noise
        wb(1, `DDC_OFF_MODE, 1);
        wb(1, `DDC_OFF_CTL, 32'h1b550015);
        d = rnd();
        wb(1, `DDC_OFF_DL12, d);
        k = n_dma;
        c = n_dma1;
        pulse(2);
        chk(ov0, d[15:4]);
        chk(ov1, 12'(d[31:20] + `DDC_LFSR_SEED));
        chk(n_dma, k);
        chk(n_dma1, c + 1);
        $display("test concurrent done");
        // Reset in mid-run returns every register and output to idle
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wb(0, `DDC_OFF_MODE, 0);
        chk(rd, 0);
        wb(0, `DDC_OFF_CTL, 0);
        chk(rd, `DDC_CTL_RST);
        chk({ov1, ov0, dma, pwr, bon}, 30'h3);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
